//--- testbench/cra_link_checker.sv
// protocol checker for the config message link between the two ends
`timescale 1ns/1ps
module cra_link_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_ctl,
  input wire logic [7:0] req_data,
  input wire logic [31:0] req_dest,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_ctl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest
);
  logic [3:0] idx_r;
  logic [7:0] op_r;
  logic [7:0] sz_r;
  logic [23:0] rid_r;
  logic in_rsp_r;
  logic [7:0] head_r;
  logic [7:0] cnt_r;
  // token handshakes and message boundaries
  wire req_take = req_valid && req_ready;
  wire rsp_take = rsp_valid && rsp_ready;
  wire req_end = req_take && req_ctl && req_data == cra_pkg::TOK_END;
  wire rsp_head = rsp_take && !in_rsp_r;
  wire rsp_tail = rsp_take && in_rsp_r && rsp_ctl
                  && rsp_data == cra_pkg::TOK_END;
  wire [3:0] idx_nxt = req_end ? 4'h0 :
                       (idx_r == 4'hF ? idx_r : idx_r + 4'h1);
  // position in request; saturates so long drains cannot wrap to opener
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx_r <= 4'h0;
      op_r <= 8'h00;
      sz_r <= 8'h00;
      rid_r <= 24'h000000;
    end else if (req_take) begin
      idx_r <= idx_nxt;
      if (idx_r == 4'h0) op_r <= req_data;
      if (idx_r >= 4'h1 && idx_r <= 4'h3) rid_r <= {rid_r[15:0], req_data};
      if (idx_r == 4'h5) sz_r <= req_data;
    end
  end
  // reply head code and count of data tokens before the tail
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      in_rsp_r <= 1'b0;
      head_r <= 8'h00;
      cnt_r <= 8'h00;
    end else if (rsp_take) begin
      in_rsp_r <= !rsp_tail;
      if (rsp_head) head_r <= rsp_data;
      cnt_r <= rsp_head ? 8'h00 : cnt_r + {7'h00, !rsp_ctl};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_req_hold;
    req_valid && !req_ready |=> req_valid && $stable(req_data)
      && $stable(req_ctl) && $stable(req_dest);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request token changed before it was taken");
  property p_reply_start;
    req_end && idx_r != 4'h0 |=> rsp_valid && rsp_ctl;
  endproperty
  a_reply_start: assert property (p_reply_start)
    else $error("no reply head after closing token");
  property p_head;
    rsp_head |-> rsp_ctl && (rsp_data == cra_pkg::TOK_ACK
      || rsp_data == cra_pkg::TOK_NAK);
  endproperty
  a_head: assert property (p_head)
    else $error("reply head is not a status token");
  property p_nak_end;
    rsp_head && rsp_data == cra_pkg::TOK_NAK |=> rsp_valid && rsp_ctl
      && rsp_data == cra_pkg::TOK_END;
  endproperty
  a_nak_end: assert property (p_nak_end)
    else $error("failure token not followed by closing token");
  property p_wr_ack;
    rsp_head && rsp_data == cra_pkg::TOK_ACK && (op_r == cra_pkg::TOK_CWR
      || op_r == cra_pkg::TOK_PWR) |=> rsp_valid && rsp_ctl
      && rsp_data == cra_pkg::TOK_END;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write success not followed by closing token");
  property p_cfg_len;
    rsp_tail && head_r == cra_pkg::TOK_ACK && op_r == cra_pkg::TOK_CRD
      |-> cnt_r == 8'h04;
  endproperty
  a_cfg_len: assert property (p_cfg_len)
    else $error("config read reply lacks four data bytes");
  property p_per_len;
    rsp_tail && head_r == cra_pkg::TOK_ACK && op_r == cra_pkg::TOK_PRD
      |-> cnt_r == sz_r;
  endproperty
  a_per_len: assert property (p_per_len)
    else $error("peripheral read reply byte count differs from size");
  property p_dest;
    rsp_valid |-> rsp_dest == rid_r;
  endproperty
  a_dest: assert property (p_dest)
    else $error("reply sent to wrong channel-end");
  property p_cfg_dest;
    req_valid && idx_r == 4'h0 && req_ctl && (req_data == cra_pkg::TOK_CWR
      || req_data == cra_pkg::TOK_CRD) |-> req_dest[15:0] ==
      cra_pkg::SFX_TILE || req_dest[15:0] == cra_pkg::SFX_NODE;
  endproperty
  a_cfg_dest: assert property (p_cfg_dest)
    else $error("config message destination suffix wrong");
  property p_per_dest;
    req_valid && idx_r == 4'h0 && req_ctl && (req_data == cra_pkg::TOK_PWR
      || req_data == cra_pkg::TOK_PRD) |-> req_dest[7:0] ==
      cra_pkg::SFX_PERI;
  endproperty
  a_per_dest: assert property (p_per_dest)
    else $error("peripheral message destination suffix wrong");
endmodule : cra_link_checker

//--- testbench/tb_config_register_message_access.sv
// bench: requester and responder joined, plus a rule-breaking driver
`timescale 1ns/1ps
module tb_config_register_message_access;
  typedef struct {
    logic ok;
    logic chk;
    logic [31:0] rd;
    logic [23:0] rid;
    logic [31:0] ps;
  } cra_tb_exp_t;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic op_write = 1'b0;
  logic [1:0] cls = 2'h0;
  logic [15:0] dev_id = 16'h0000;
  logic [7:0] periph_id = 8'h00;
  logic [23:0] reply_id = 24'h000000;
  logic [15:0] reg_num = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [7:0] size = 8'h00;
  logic req_busy, req_done, req_ok, dev_busy, dev_done, dev_ok;
  logic [31:0] req_rdata, req_ps, d;
  int failures = 0;
  int num_checks = 0;
  cra_tb_exp_t q[$];
  cra_tb_exp_t e;
  cra_link_if lnk();
  cra_link_if lnk2();
  cra_dev cra_dev_i (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk),
    .busy(dev_busy), .done(dev_done), .ok(dev_ok));
  cra_dev cra_dev2_i (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk2),
    .busy(), .done(), .ok());
  cra_req cra_req_i (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk),
    .start(start), .op_write(op_write), .cls(cls), .dev_id(dev_id),
    .periph_id(periph_id), .reply_id(reply_id), .reg_num(reg_num),
    .wdata(wdata), .size(size), .busy(req_busy), .done(req_done),
    .ok(req_ok), .rdata(req_rdata), .ps_resid(req_ps));
  cra_link_checker cra_link_checker_i (.clk_sys(clk_sys), .nrst(nrst),
    .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
    .req_ctl(lnk.req_ctl), .req_data(lnk.req_data),
    .req_dest(lnk.req_dest), .rsp_valid(lnk.rsp_valid),
    .rsp_ready(lnk.rsp_ready), .rsp_ctl(lnk.rsp_ctl),
    .rsp_data(lnk.rsp_data), .rsp_dest(lnk.rsp_dest));
  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // one message through the requester; outcome noted for the monitor
  task automatic run(input logic wr, input logic [1:0] c,
    input logic [15:0] r, input logic [31:0] wd, input logic [7:0] sz,
    input logic eok, input logic ck, input logic [31:0] erd);
    logic [23:0] rid;
    int n;
    rid = 24'($urandom);
    @(posedge clk_sys);
    op_write <= wr;
    cls <= c;
    reg_num <= r;
    wdata <= wd;
    size <= sz;
    dev_id <= 16'($urandom);
    periph_id <= 8'($urandom);
    reply_id <= rid;
    start <= 1'b1;
    q.push_back('{eok, ck, erd, rid, (32'(r) << cra_pkg::PS_SHIFT)
      | 32'(cra_pkg::PS_CODE)});
    @(posedge clk_sys);
    start <= 1'b0;
    for (n = 0; n < 200 && req_done !== 1'b1; n++) @(negedge clk_sys);
    if (n == 200) chk(1'b0, "no completion");
    @(posedge clk_sys);
  endtask : run
  // one token on the second link, held until the responder takes it
  task automatic tok2(input logic c, input logic [7:0] v);
    int n;
    @(posedge clk_sys);
    lnk2.req_valid <= 1'b1;
    lnk2.req_ctl <= c;
    lnk2.req_data <= v;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (lnk2.req_ready === 1'b1) break;
    end
    lnk2.req_valid <= 1'b0;
  endtask : tok2
  // broken opener: reply must be failure then close, to the carried id
  task automatic bad2(input logic c, input logic [7:0] v);
    logic [23:0] rid;
    logic [7:0] ex[2];
    int k, n;
    rid = 24'($urandom);
    ex = '{cra_pkg::TOK_NAK, cra_pkg::TOK_END};
    tok2(c, v);
    for (k = 2; k >= 0; k--) tok2(1'b0, rid[8*k +: 8]);
    tok2(1'b1, cra_pkg::TOK_END);
    for (k = 0; k < 2; k++) begin
      for (n = 0; n < 20 && lnk2.rsp_valid !== 1'b1; n++)
        @(negedge clk_sys);
      chk(lnk2.rsp_ctl === 1'b1 && lnk2.rsp_data === ex[k],
        "bad reply");
      chk(lnk2.rsp_dest === rid, "bad reply dest");
      @(negedge clk_sys);
    end
  endtask : bad2
  // monitor: oldest note against each completed message
  always @(negedge clk_sys) begin
    if (lnk.rsp_valid === 1'b1 && q.size() > 0)
      chk(lnk.rsp_dest === q[0].rid, "reply dest");
    if (lnk.rsp_valid === 1'b1)
      chk(dev_busy === 1'b1 && req_busy === 1'b1, "busy");
    if (req_done === 1'b1) begin
      if (q.size() == 0) chk(1'b0, "unexpected completion");
      else begin
        e = q.pop_front();
        chk(req_ok === e.ok, "status");
        chk(dev_done === 1'b1 && dev_ok === e.ok, "device status");
        chk(req_busy === 1'b0 && dev_busy === 1'b0, "idle");
        chk(req_ps === e.ps, "status id");
        if (e.chk) chk(req_rdata === e.rd, "read data");
      end
    end
  end
  // main sequence
  initial begin
    lnk2.req_valid = 1'b0;
    lnk2.req_ctl = 1'b0;
    lnk2.req_data = 8'h00;
    lnk2.req_dest = {16'h0000, cra_pkg::SFX_TILE};
    lnk2.rsp_ready = 1'b1;
    void'($urandom(68));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    d = $urandom;
    run(1'b1, cra_pkg::CLS_TILE, 16'h0005, d, 8'h04, 1'b1, 1'b0, d);
    run(1'b1, cra_pkg::CLS_NODE, 16'h0005, ~d, 8'h04, 1'b1, 1'b0, d);
    run(1'b0, cra_pkg::CLS_TILE, 16'h0005, d, 8'h04, 1'b1, 1'b1, d);
    run(1'b0, cra_pkg::CLS_NODE, 16'h0005, d, 8'h04, 1'b1, 1'b1, ~d);
    run(1'b1, cra_pkg::CLS_PERI, 16'h000C, d, 8'h04, 1'b1, 1'b0, d);
    run(1'b0, cra_pkg::CLS_PERI, 16'h000C, d, 8'h04, 1'b1, 1'b1, d);
    run(1'b0, cra_pkg::CLS_PERI, 16'h0000, d, 8'h00, 1'b1, 1'b0, d);
    run(1'b0, cra_pkg::CLS_TILE, 16'h0010, d, 8'h04, 1'b0, 1'b0, d);
    run(1'b1, cra_pkg::CLS_NODE, 16'hFFFF, d, 8'h04, 1'b0, 1'b0, d);
    run(1'b0, cra_pkg::CLS_PERI, 16'h000D, d, 8'h04, 1'b0, 1'b0, d);
    run(1'b0, cra_pkg::CLS_TILE, 16'h0005, d, 8'h04, 1'b1, 1'b1, d);
    bad2(1'b1, 8'h55);
    bad2(1'b0, cra_pkg::TOK_CWR);
    results();
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule : tb_config_register_message_access

//--- verilog/cra_dev.sv
// configuration register responder: parses messages, stores, replies
`timescale 1ns/1ps
module cra_dev (
  input wire logic clk_sys,
  input wire logic nrst,
  cra_link_if.dev lnk,
  output logic busy,
  output logic done,
  output logic ok
);
  typedef enum logic [3:0] {
    CRA_IDLE = 4'h0,
    CRA_RID = 4'h1,
    CRA_REG = 4'h3,
    CRA_SIZE = 4'h2,
    CRA_DATA = 4'h6,
    CRA_END = 4'h7,
    CRA_RHEAD = 4'h5,
    CRA_RDATA = 4'h4,
    CRA_RTAIL = 4'hC,
    CRA_DRAIN = 4'hD
  } cra_st_t;

  cra_st_t st_r;
  cra_st_t st_nxt;
  logic ready_r;
  logic rsp_valid_r;
  logic rsp_ctl_r;
  logic [7:0] rsp_data_r;
  logic [23:0] rsp_dest_r;
  logic busy_r;
  logic done_r;
  logic ok_r;
  logic [7:0] op_r;
  logic [1:0] cls_r;
  logic bad_r;
  logic fail_r;
  logic [23:0] rid_r;
  logic [15:0] reg_r;
  logic [7:0] size_r;
  logic [7:0] cnt_r;
  logic [31:0] wd_r;
  logic [31:0] rd_r;
  logic [31:0] cmem [0:2*cra_pkg::CFG_DEPTH-1];
  logic [7:0] pmem [0:cra_pkg::PER_DEPTH-1];

  // operation decode, reused for the opening token and the stored one
  function automatic logic op_known(input logic [7:0] t);
    op_known = (t == cra_pkg::TOK_CWR) || (t == cra_pkg::TOK_CRD) ||
               (t == cra_pkg::TOK_PWR) || (t == cra_pkg::TOK_PRD);
  endfunction : op_known

  function automatic logic op_cfg(input logic [7:0] t);
    op_cfg = (t == cra_pkg::TOK_CWR) || (t == cra_pkg::TOK_CRD);
  endfunction : op_cfg

  function automatic logic op_wr(input logic [7:0] t);
    op_wr = (t == cra_pkg::TOK_CWR) || (t == cra_pkg::TOK_PWR);
  endfunction : op_wr

  // link strobes and message classification
  wire take = lnk.req_valid && ready_r;
  wire tok_end = lnk.req_ctl && (lnk.req_data == cra_pkg::TOK_END);
  wire give = rsp_valid_r && lnk.rsp_ready;
  wire is_cfg = op_cfg(op_r);
  wire is_wr = op_wr(op_r);
  wire last = (cnt_r == 8'h01);
  wire [15:0] dsfx = lnk.req_dest[15:0];
  // the destination suffix selects which register class is reached
  wire dst_tile = (dsfx == cra_pkg::SFX_TILE);
  wire dst_node = (dsfx == cra_pkg::SFX_NODE);
  wire dst_peri = (lnk.req_dest[7:0] == cra_pkg::SFX_PERI);
  wire cls_ok = op_cfg(lnk.req_data) ? (dst_tile || dst_node) : dst_peri;
  wire [1:0] cls_in = dst_tile ? cra_pkg::CLS_TILE :
                      dst_node ? cra_pkg::CLS_NODE : cra_pkg::CLS_PERI;
  // register numbers beyond the store fail instead of aliasing
  wire creg_ok = (reg_r < 16'(cra_pkg::CFG_DEPTH));
  wire creg_in_ok = ({reg_r[7:0], rx_byte} < 16'(cra_pkg::CFG_DEPTH));
  wire [4:0] caddr = {cls_r[0], reg_r[3:0]};
  wire [8:0] pend = {1'b0, reg_r[7:0]} + {1'b0, lnk.req_data};
  wire preg_fit = (pend <= 9'(cra_pkg::PER_DEPTH));
  wire [7:0] pidx = reg_r[7:0] + (size_r - cnt_r);
  wire [3:0] pa = pidx[3:0];
  // a reply byte is fetched one step ahead of the count being taken
  wire [3:0] pa_rd = (st_r == CRA_RDATA) ? pa + 4'h1 : pa;
  wire [7:0] rx_byte = lnk.req_data;
  wire good_end = tok_end && !fail_r;

  // next state: a control token in a data slot cuts the message short
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      CRA_IDLE: begin
        if (take && !tok_end) begin
          st_nxt = CRA_RID;
        end
      end
      CRA_RID: begin
        if (take && lnk.req_ctl) begin
          st_nxt = tok_end ? CRA_RHEAD : CRA_DRAIN;
        end else if (take && last) begin
          st_nxt = bad_r ? CRA_DRAIN : CRA_REG;
        end
      end
      CRA_REG: begin
        if (take && lnk.req_ctl) begin
          st_nxt = tok_end ? CRA_RHEAD : CRA_DRAIN;
        end else if (take && last) begin
          st_nxt = !is_cfg ? CRA_SIZE : is_wr ? CRA_DATA : CRA_END;
        end
      end
      CRA_SIZE: begin
        if (take && lnk.req_ctl) begin
          st_nxt = tok_end ? CRA_RHEAD : CRA_DRAIN;
        end else if (take) begin
          st_nxt = (is_wr && rx_byte != 8'h00) ? CRA_DATA : CRA_END;
        end
      end
      CRA_DATA: begin
        if (take && lnk.req_ctl) begin
          st_nxt = tok_end ? CRA_RHEAD : CRA_DRAIN;
        end else if (take && last) begin
          st_nxt = CRA_END;
        end
      end
      CRA_END: begin
        if (take) begin
          st_nxt = tok_end ? CRA_RHEAD : CRA_DRAIN;
        end
      end
      CRA_DRAIN: begin
        if (take && tok_end) begin
          st_nxt = CRA_RHEAD;
        end
      end
      CRA_RHEAD: begin
        if (give) begin
          st_nxt = (!fail_r && !is_wr && cnt_r != 8'h00) ? CRA_RDATA :
                   CRA_RTAIL;
        end
      end
      CRA_RDATA: begin
        if (give && last) begin
          st_nxt = CRA_RTAIL;
        end
      end
      CRA_RTAIL: begin
        if (give) begin
          st_nxt = CRA_IDLE;
        end
      end
      default: st_nxt = CRA_IDLE;
    endcase
  end

  // ready follows the next state so it never accepts a token it ignores
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= CRA_IDLE;
      ready_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ready_r <= (st_nxt != CRA_RHEAD) && (st_nxt != CRA_RDATA) &&
                 (st_nxt != CRA_RTAIL);
      busy_r <= (st_nxt != CRA_IDLE);
    end
  end

  // message capture; fields arrive most significant byte first
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      op_r <= 8'h00;
      cls_r <= 2'h0;
      bad_r <= 1'b0;
      fail_r <= 1'b0;
      rid_r <= 24'h000000;
      reg_r <= 16'h0000;
      size_r <= 8'h00;
      cnt_r <= 8'h00;
      wd_r <= 32'h00000000;
    end else if (take) begin
      if (st_r == CRA_IDLE) begin
        op_r <= lnk.req_data;
        cls_r <= cls_in;
        // unknown opening token or a wrong destination fails
        bad_r <= !(lnk.req_ctl && op_known(lnk.req_data));
        fail_r <= !(lnk.req_ctl && op_known(lnk.req_data) && cls_ok);
        cnt_r <= cra_pkg::RID_BYTES;
        reg_r <= 16'h0000;
        size_r <= 8'h00;
      end else if (lnk.req_ctl && st_r != CRA_DRAIN) begin
        fail_r <= fail_r || !(tok_end && st_r == CRA_END);
      end else if (!lnk.req_ctl) begin
        cnt_r <= cnt_r - 8'h01;
        case (st_r)
          CRA_RID: begin
            rid_r <= {rid_r[15:0], rx_byte};
            if (last) begin
              cnt_r <= is_cfg ? cra_pkg::CREG_BYTES : cra_pkg::PREG_BYTES;
            end
          end
          CRA_REG: begin
            reg_r <= {reg_r[7:0], rx_byte};
            if (last) begin
              cnt_r <= cra_pkg::WORD_BYTES;
              fail_r <= fail_r || (is_cfg && !creg_in_ok);
            end
          end
          CRA_SIZE: begin
            size_r <= rx_byte;
            cnt_r <= rx_byte;
            fail_r <= fail_r || !preg_fit;
          end
          CRA_DATA: begin
            wd_r <= {wd_r[23:0], rx_byte};
          end
          CRA_END: begin
            fail_r <= 1'b1;
          end
          default: cnt_r <= cnt_r;
        endcase
      end
    end else if (give && st_r == CRA_RDATA) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  // register stores: config words commit only on a clean close
  always_ff @(posedge clk_sys) begin
    if (take && good_end && st_r == CRA_END && is_cfg && is_wr && creg_ok) begin
      cmem[caddr] <= wd_r;
    end
    if (take && !lnk.req_ctl && st_r == CRA_DATA && !is_cfg && !fail_r) begin
      pmem[pa] <= rx_byte;
    end
  end

  // reply path: head, optional payload, closing token 1
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp_valid_r <= 1'b0;
      rsp_ctl_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_dest_r <= 24'h000000;
      rd_r <= 32'h00000000;
      done_r <= 1'b0;
      ok_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (st_nxt == CRA_RHEAD && st_r != CRA_RHEAD) begin
        rsp_valid_r <= 1'b1;
        rsp_ctl_r <= 1'b1;
        // head is the success or failure token; after a failure head comes the closing token, no payload
        rsp_data_r <= fail_r ? cra_pkg::TOK_NAK : cra_pkg::TOK_ACK;
        rsp_dest_r <= rid_r;
        rd_r <= cmem[caddr];
      end else if (give && st_nxt == CRA_RDATA) begin
        rsp_ctl_r <= 1'b0;
        if (is_cfg) begin
          rsp_data_r <= rd_r[31:24];
          rd_r <= {rd_r[23:0], 8'h00};
        end else begin
          rsp_data_r <= pmem[pa_rd];
        end
      end else if (give && st_nxt == CRA_RTAIL) begin
        rsp_ctl_r <= 1'b1;
        rsp_data_r <= cra_pkg::TOK_END;
      end else if (give && st_r == CRA_RTAIL) begin
        rsp_valid_r <= 1'b0;
        done_r <= 1'b1;
        ok_r <= !fail_r;
      end
    end
  end

  assign lnk.req_ready = ready_r;
  assign lnk.rsp_valid = rsp_valid_r;
  assign lnk.rsp_ctl = rsp_ctl_r;
  assign lnk.rsp_data = rsp_data_r;
  assign lnk.rsp_dest = rsp_dest_r;
  assign busy = busy_r;
  assign done = done_r;
  assign ok = ok_r;
endmodule : cra_dev

//--- verilog/cra_link_if.sv
// token link between a requesting channel-end and the config responder
`timescale 1ns/1ps
interface cra_link_if;
  logic req_valid;
  logic req_ready;
  logic req_ctl;
  logic [7:0] req_data;
  logic [31:0] req_dest;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_ctl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  modport dev (input req_valid, req_ctl, req_data, req_dest, rsp_ready,
               output req_ready, rsp_valid, rsp_ctl, rsp_data, rsp_dest);
  modport req (output req_valid, req_ctl, req_data, req_dest, rsp_ready,
               input req_ready, rsp_valid, rsp_ctl, rsp_data, rsp_dest);
endinterface : cra_link_if

//--- verilog/cra_pkg.sv
// constants shared by both ends of the configuration message link
package cra_pkg;
  localparam logic [7:0] TOK_END = 8'h01;     // closing control token 1
  localparam logic [7:0] TOK_ACK = 8'h03;     // success control token 3
  localparam logic [7:0] TOK_NAK = 8'h04;     // failure control token 4
  localparam logic [7:0] TOK_PWR = 8'h24;     // peripheral write, 36
  localparam logic [7:0] TOK_PRD = 8'h25;     // peripheral read, 37
  localparam logic [7:0] TOK_CWR = 8'hC0;     // config write, 192
  localparam logic [7:0] TOK_CRD = 8'hC1;     // config read, 193
  localparam logic [15:0] SFX_TILE = 16'hC20C; // tile config suffix
  localparam logic [15:0] SFX_NODE = 16'hC30C; // node config suffix
  localparam logic [7:0] SFX_PERI = 8'h02;    // peripheral suffix
  localparam logic [7:0] PS_CODE = 8'h0C;     // status resource low byte
  localparam int PS_SHIFT = 8;                // status register shift
  localparam logic [7:0] RID_BYTES = 8'h03;   // 24-bit reply identifier
  localparam logic [7:0] CREG_BYTES = 8'h02;  // 16-bit register number
  localparam logic [7:0] PREG_BYTES = 8'h01;  // 8-bit register number
  localparam logic [7:0] WORD_BYTES = 8'h04;  // 32-bit data word
  localparam int CFG_DEPTH = 16;              // words per config class
  localparam int PER_DEPTH = 16;              // peripheral bytes held
  localparam logic [1:0] CLS_TILE = 2'h0;
  localparam logic [1:0] CLS_NODE = 2'h1;
  localparam logic [1:0] CLS_PERI = 2'h2;
endpackage : cra_pkg

//--- verilog/cra_req.sv
// requesting channel-end: builds one message, collects the reply
`timescale 1ns/1ps
module cra_req (
  input wire logic clk_sys,
  input wire logic nrst,
  cra_link_if.req lnk,
  input wire logic start,
  input wire logic op_write,
  input wire logic [1:0] cls,
  input wire logic [15:0] dev_id,
  input wire logic [7:0] periph_id,
  input wire logic [23:0] reply_id,
  input wire logic [15:0] reg_num,
  input wire logic [31:0] wdata,
  input wire logic [7:0] size,
  output logic busy,
  output logic done,
  output logic ok,
  output logic [31:0] rdata,
  output logic [31:0] ps_resid
);
  typedef enum logic [1:0] {
    CRQ_IDLE = 2'h0,
    CRQ_SEND = 2'h1,
    CRQ_WAIT = 2'h3
  } crq_st_t;

  crq_st_t st_r;
  logic valid_r;
  logic ctl_r;
  logic [7:0] data_r;
  logic [31:0] dest_r;
  logic rready_r;
  logic done_r;
  logic ok_r;
  logic [31:0] rdata_r;
  logic [31:0] ps_r;
  logic wr_r;
  logic cfg_r;
  logic [23:0] rid_r;
  logic [15:0] reg_r;
  logic [31:0] wd_r;
  logic [7:0] size_r;
  logic [7:0] ix_r;

  // token at position i of the message, control flag in bit 8
  function automatic logic [8:0] tok_at(input logic [7:0] i,
                                        input logic cfg,
                                        input logic wr,
                                        input logic [7:0] sz,
                                        input logic [23:0] rid,
                                        input logic [15:0] rg,
                                        input logic [31:0] wd);
    logic [7:0] rb;
    logic [7:0] db;
    logic [7:0] k;
    rb = cfg ? 8'h06 : 8'h05;
    db = wr ? (cfg ? 8'h04 : sz) : 8'h00;
    k = 8'h00;
    if (i == 8'h00) begin
      tok_at = {1'b1, cfg ? (wr ? cra_pkg::TOK_CWR : cra_pkg::TOK_CRD) :
                (wr ? cra_pkg::TOK_PWR : cra_pkg::TOK_PRD)};
    end else if (i < 8'h04) begin
      k = i - 8'h01;
      tok_at = {1'b0, rid[23 - 8*k[1:0] -: 8]};
    end else if (i < rb) begin
      tok_at = {1'b0, (cfg && i == 8'h04) ? rg[15:8] : rg[7:0]};
    end else if (!cfg && i == 8'h05) begin
      tok_at = {1'b0, sz};
    end else if (i < rb + (cfg ? 8'h00 : 8'h01) + db) begin
      k = i - rb - (cfg ? 8'h00 : 8'h01);
      tok_at = {1'b0, wd[31 - 8*k[1:0] -: 8]};
    end else begin
      tok_at = {1'b1, cra_pkg::TOK_END};
    end
  endfunction : tok_at

  // destination and status id formed from the user fields
  wire is_cfg = (cls != cra_pkg::CLS_PERI);
  wire [31:0] dest_in = (cls == cra_pkg::CLS_TILE) ?
                        {dev_id, cra_pkg::SFX_TILE} :
                        (cls == cra_pkg::CLS_NODE) ?
                        {dev_id, cra_pkg::SFX_NODE} :
                        {dev_id, periph_id, cra_pkg::SFX_PERI};
  wire [31:0] ps_in = ({16'h0000, reg_num} << cra_pkg::PS_SHIFT) |
                      {24'h000000, cra_pkg::PS_CODE};
  wire [8:0] tok0 = tok_at(8'h00, is_cfg, op_write, size, reply_id,
                           reg_num, wdata);
  wire [8:0] tokn = tok_at(ix_r + 8'h01, cfg_r, wr_r, size_r, rid_r,
                           reg_r, wd_r);
  wire sent = valid_r && lnk.req_ready;
  wire got = rready_r && lnk.rsp_valid;

  // sender: one token held until taken, end token closes the message
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= CRQ_IDLE;
      valid_r <= 1'b0;
      ctl_r <= 1'b0;
      data_r <= 8'h00;
      dest_r <= 32'h00000000;
      ps_r <= 32'h00000000;
      wr_r <= 1'b0;
      cfg_r <= 1'b0;
      rid_r <= 24'h000000;
      reg_r <= 16'h0000;
      wd_r <= 32'h00000000;
      size_r <= 8'h00;
      ix_r <= 8'h00;
      rready_r <= 1'b0;
    end else if (st_r == CRQ_IDLE && start) begin
      st_r <= CRQ_SEND;
      dest_r <= dest_in;
      ps_r <= ps_in;
      wr_r <= op_write;
      cfg_r <= is_cfg;
      rid_r <= reply_id;
      reg_r <= reg_num;
      wd_r <= wdata;
      size_r <= size;
      ix_r <= 8'h00;
      valid_r <= 1'b1;
      ctl_r <= tok0[8];
      data_r <= tok0[7:0];
    end else if (st_r == CRQ_SEND && sent) begin
      if (ctl_r && data_r == cra_pkg::TOK_END) begin
        valid_r <= 1'b0;
        rready_r <= 1'b1;
        st_r <= CRQ_WAIT;
      end else begin
        ix_r <= ix_r + 8'h01;
        ctl_r <= tokn[8];
        data_r <= tokn[7:0];
      end
    end else if (st_r == CRQ_WAIT && got && lnk.rsp_ctl &&
                 lnk.rsp_data == cra_pkg::TOK_END) begin
      rready_r <= 1'b0;
      st_r <= CRQ_IDLE;
    end
  end

  // receiver: head token gives the verdict, data bytes shift in
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
      ok_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      done_r <= 1'b0;
      if (st_r == CRQ_IDLE && start) begin
        rdata_r <= 32'h00000000;
      end else if (got && lnk.rsp_ctl) begin
        if (lnk.rsp_data == cra_pkg::TOK_END) begin
          done_r <= 1'b1;
        end else begin
          ok_r <= (lnk.rsp_data == cra_pkg::TOK_ACK);
        end
      end else if (got) begin
        rdata_r <= {rdata_r[23:0], lnk.rsp_data};
      end
    end
  end

  assign lnk.req_valid = valid_r;
  assign lnk.req_ctl = ctl_r;
  assign lnk.req_data = data_r;
  assign lnk.req_dest = dest_r;
  assign lnk.rsp_ready = rready_r;
  assign busy = st_r[0]; // bit 0 is set in every non-idle state
  assign done = done_r;
  assign ok = ok_r;
  assign rdata = rdata_r;
  assign ps_resid = ps_r;
endmodule : cra_req
